// ===== core_model.sv
`timescale 1ns/1ps
module core_model (
   // Clock, reset and control
   input  wire clk_i,
   input  wire reset_i,
   input  wire serve_i,
   // Service handshake
   input  wire irq_req_i,
   output reg  ack_o  = 1'b0,
   output reg  reti_o = 1'b0,
   output reg  done_o = 1'b0
);
   reg [3:0] cnt_reg = 4'h0;
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      reti_o <= 1'b0;
      done_o <= 1'b0;
      if (reset_i) begin
         cnt_reg <= 4'h0;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg + 4'h1;
         reti_o <= (cnt_reg == 4'hA);
         if (cnt_reg == 4'hC) begin // One instruction after the return
            done_o <= 1'b1;
            cnt_reg <= 4'h0;
         end
      end else if (serve_i && irq_req_i) begin
         ack_o <= 1'b1;
         cnt_reg <= 4'h1;
      end
   end
endmodule

// ===== irq_prio_checker.sv
`timescale 1ns/1ps
module irq_prio_checker #(
   parameter SRC_N = 9
) (
   // Clock, reset and register port
   input wire             clk_i,
   input wire             reset_i,
   input wire [7:0]       sfr_addr_i,
   input wire             sfr_wr_i,
   input wire             sfr_bit_wr_i,
   input wire [2:0]       sfr_bit_sel_i,
   input wire [7:0]       sfr_rdata_o,
   input wire             sfr_bit_rdata_o,
   // Interrupt side
   input wire             global_irq_enable_i,
   input wire [SRC_N-1:0] irq_pending_i,
   input wire             irq_ack_i,
   input wire             reti_i,
   input wire             irq_req_o,
   input wire [3:0]       irq_src_o,
   input wire             irq_high_o,
   input wire [SRC_N-1:0] src_high_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   reg  [SRC_N-1:0] pend_reg;
   wire             wr_any = sfr_wr_i | sfr_bit_wr_i;
   always @(posedge clk_i) begin
      pend_reg <= irq_pending_i;
   end
   AST_FIXED_ONE: assert property (sfr_addr_i == 8'hB8 |=> sfr_rdata_o[7])
      else $error("fixed bit reads low");
   AST_BIT_TEST7: assert property (sfr_addr_i == 8'hB8 && sfr_bit_sel_i == 3'h7 |=> sfr_bit_rdata_o)
      else $error("bit test of fixed bit low");
   AST_EXT_ZERO: assert property ((sfr_addr_i == 8'hE6 || sfr_addr_i == 8'hF6) |=> sfr_rdata_o[7:5] == 3'h0)
      else $error("upper extended bits set");
   AST_GLOBAL_OFF: assert property (!global_irq_enable_i |=> !irq_req_o)
      else $error("request while globally off");
   AST_SRC_PEND: assert property (irq_req_o |-> pend_reg[irq_src_o])
      else $error("request for idle source");
   AST_HIGH_MATCH: assert property (irq_req_o && !$past(wr_any) && !$past(wr_any, 2) |-> irq_high_o == src_high_o[irq_src_o])
      else $error("level flag mismatch");
   AST_HIGH_ACK: assert property (irq_req_o && irq_ack_i && irq_high_o |=> !irq_req_o)
      else $error("request during high service");
   AST_RETI_HOLD: assert property (reti_i |=> !irq_req_o)
      else $error("request right after return");
endmodule
bind irq_priority_ext_enable irq_prio_checker #(.SRC_N(SRC_N)) u_chk (.clk_i, .reset_i, .sfr_addr_i,
   .sfr_wr_i, .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_rdata_o, .sfr_bit_rdata_o, .global_irq_enable_i,
   .irq_pending_i, .irq_ack_i, .reti_i, .irq_req_o, .irq_src_o, .irq_high_o, .src_high_o);

// ===== irq_priority_ext_enable.v
`timescale 1ns/1ps
`include "irq_priority_regs.vh"

module irq_priority_ext_enable #(
   parameter SRC_N = `SRC_COUNT
) (
   // Clock and reset
   input  wire                 clk_i,
   input  wire                 reset_i,
   // Special function register port
   input  wire [7:0]           sfr_addr_i,
   input  wire                 sfr_wr_i,
   input  wire [7:0]           sfr_wdata_i,
   input  wire                 sfr_bit_wr_i,
   input  wire [2:0]           sfr_bit_sel_i,
   input  wire                 sfr_bit_val_i,
   output reg  [7:0]           sfr_rdata_o,
   output reg                  sfr_bit_rdata_o,
   // Primary enables held by the core
   input  wire                 global_irq_enable_i,
   input  wire [5:0]           primary_enable_i,
   // Pending flags from the sources
   input  wire [SRC_N-1:0]     irq_pending_i,
   // Core service handshake
   input  wire                 irq_ack_i,
   input  wire                 reti_i,
   input  wire                 instr_done_i,
   output reg                  irq_req_o,
   output reg  [`SRC_IDX_W-1:0] irq_src_o,
   output reg                  irq_high_o,
   // Level bits for other logic
   output reg  [SRC_N-1:0]     src_high_o
);

   reg  [7:0] irq_level_select_reg;
   reg  [7:0] irq_level_select_next;
   reg  [7:0] extended_irq_enable_reg;
   reg  [7:0] extended_irq_level_reg;
   reg  [1:0] active_top_reg;
   reg  [1:0] active_low_reg;
   reg        hold_reg;
   reg        hold_arm_reg;

   wire [SRC_N-1:0] enable_vec;
   wire [SRC_N-1:0] level_vec;
   wire [SRC_N-1:0] live_vec;
   wire [7:0]       ext_en_read;
   wire [7:0]       ext_lvl_read;
   wire [7:0]       lvl_read;

   assign lvl_read     = irq_level_select_reg | `IRQ_LEVEL_SELECT_RESET;
   assign ext_en_read  = extended_irq_enable_reg & `EXT_IRQ_READ_MASK;
   assign ext_lvl_read = extended_irq_level_reg & `EXT_IRQ_READ_MASK;

   // Register bit that holds the level of each source, and the enable of the extended ones
   function integer src_bit;
      input integer src;
      begin
         case (src)
            `SRC_EXT_EDGE0:    src_bit = `LVL_EXT_EDGE0_BIT;
            `SRC_TIMER2:       src_bit = `LVL_TIMER2_BIT;
            `SRC_CLOCK_TICK:   src_bit = `LVL_CLOCK_TICK_BIT;
            `SRC_SERIALIZER:   src_bit = `LVL_SERIALIZER_BIT;
            `SRC_TIMER3:       src_bit = `LVL_TIMER3_BIT;
            `SRC_EXT_EDGE1:    src_bit = `LVL_EXT_EDGE1_BIT;
            `SRC_FREQ_COUNTER: src_bit = `EXT_FREQ_COUNTER_BIT;
            `SRC_SPARE0:       src_bit = `EXT_SPARE0_BIT;
            `SRC_SPARE1:       src_bit = `EXT_SPARE1_BIT;
            default:           src_bit = 0;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < SRC_N; g = g + 1) begin : gate_g
         if (g < `SRC_FREQ_COUNTER) begin : prim_g
            assign level_vec[g]  = irq_level_select_reg[src_bit(g)];
            assign enable_vec[g] = primary_enable_i[g];
         end else begin : ext_g
            assign level_vec[g]  = extended_irq_level_reg[src_bit(g)];
            assign enable_vec[g] = extended_irq_enable_reg[src_bit(g)];
         end
         assign live_vec[g] = irq_pending_i[g] & enable_vec[g] & global_irq_enable_i;
      end
   endgenerate

   // Pick lowest index among high requests, else among low requests
   reg                  high_found;
   reg                  low_found;
   reg [`SRC_IDX_W-1:0] high_idx;
   reg [`SRC_IDX_W-1:0] low_idx;
   integer i;
   always @* begin
      high_found = 1'b0;
      low_found  = 1'b0;
      high_idx   = {`SRC_IDX_W{1'b0}};
      low_idx    = {`SRC_IDX_W{1'b0}};
      for (i = SRC_N - 1; i >= 0; i = i - 1) begin
         if (live_vec[i] && level_vec[i]) begin
            high_found = 1'b1;
            high_idx   = i[`SRC_IDX_W-1:0];
         end
         if (live_vec[i] && !level_vec[i]) begin
            low_found = 1'b1;
            low_idx   = i[`SRC_IDX_W-1:0];
         end
      end
   end

   // A request may preempt only a strictly lower running level
   reg                  cand_ok;
   reg                  cand_high;
   reg [`SRC_IDX_W-1:0] cand_idx;
   always @* begin
      cand_high = high_found;
      cand_idx  = high_found ? high_idx : low_idx;
      cand_ok   = 1'b0;
      if (!hold_reg) begin
         if (high_found)
            cand_ok = (active_top_reg != `LEVEL_HIGH);
         else if (low_found)
            cand_ok = (active_top_reg == `LEVEL_NONE);
      end
   end

   // Byte and bit writes to the primary level register
   always @* begin
      irq_level_select_next = irq_level_select_reg;
      if (sfr_wr_i && sfr_addr_i == `IRQ_LEVEL_SELECT_ADDR)
         irq_level_select_next = (sfr_wdata_i & `IRQ_LEVEL_SELECT_WMASK)
                               | `IRQ_LEVEL_SELECT_RESET;
      else if (sfr_bit_wr_i && sfr_addr_i == `IRQ_LEVEL_SELECT_ADDR
               && sfr_bit_sel_i != `LVL_FIXED_ONE_SEL)
         irq_level_select_next[sfr_bit_sel_i] = sfr_bit_val_i;
   end

   // Bit 7 starts at one and no write path clears it
   always @(posedge clk_i) begin
      if (reset_i) begin
         irq_level_select_reg <= `IRQ_LEVEL_SELECT_RESET;
      end else begin
         irq_level_select_reg <= irq_level_select_next;
      end
   end

   reg  [7:0] extended_irq_enable_next;
   reg  [7:0] extended_irq_level_next;

   // Upper bits are dropped at the write, so they can never read back set
   always @* begin
      extended_irq_enable_next = extended_irq_enable_reg;
      extended_irq_level_next  = extended_irq_level_reg;
      if (sfr_wr_i && sfr_addr_i == `EXT_IRQ_ENABLE_ADDR)
         extended_irq_enable_next = sfr_wdata_i & `EXT_IRQ_WMASK;
      if (sfr_wr_i && sfr_addr_i == `EXT_IRQ_LEVEL_ADDR)
         extended_irq_level_next = sfr_wdata_i & `EXT_IRQ_WMASK;
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         extended_irq_enable_reg <= `EXT_IRQ_ENABLE_RESET;
         extended_irq_level_reg  <= `EXT_IRQ_LEVEL_RESET;
      end else begin
         extended_irq_enable_reg <= extended_irq_enable_next;
         extended_irq_level_reg  <= extended_irq_level_next;
      end
   end

   reg  [7:0] rdata_next;
   reg        bit_rdata_next;

   // Read data follows the address one cycle later; unmapped addresses read zero
   always @* begin
      case (sfr_addr_i)
         `IRQ_LEVEL_SELECT_ADDR: rdata_next = lvl_read;
         `EXT_IRQ_ENABLE_ADDR:   rdata_next = ext_en_read;
         `EXT_IRQ_LEVEL_ADDR:    rdata_next = ext_lvl_read;
         default:                rdata_next = 8'h00;
      endcase
      bit_rdata_next = 1'b0;
      if (sfr_addr_i == `IRQ_LEVEL_SELECT_ADDR)
         bit_rdata_next = lvl_read[sfr_bit_sel_i];
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         sfr_rdata_o     <= 8'h00;
         sfr_bit_rdata_o <= 1'b0;
      end else begin
         sfr_rdata_o     <= rdata_next;
         sfr_bit_rdata_o <= bit_rdata_next;
      end
   end

   reg  [1:0] active_top_next;
   reg  [1:0] active_low_next;
   reg        hold_next;
   reg        hold_arm_next;
   wire       req_taken;

   // An acknowledge only counts while a request is shown
   assign req_taken = irq_ack_i & irq_req_o;

   // Two levels of nesting: the running level and the one it preempted
   always @* begin
      active_top_next = active_top_reg;
      active_low_next = active_low_reg;
      if (req_taken) begin
         active_low_next = active_top_reg;
         active_top_next = irq_high_o ? `LEVEL_HIGH : `LEVEL_LOW;
      end else if (reti_i) begin
         active_top_next = active_low_reg;
         active_low_next = `LEVEL_NONE;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         active_top_reg <= `LEVEL_NONE;
         active_low_reg <= `LEVEL_NONE;
      end else begin
         active_top_reg <= active_top_next;
         active_low_reg <= active_low_next;
      end
   end

   // One more instruction must finish after a return
   always @* begin
      hold_next     = hold_reg;
      hold_arm_next = hold_arm_reg;
      if (reti_i) begin
         hold_next     = 1'b1;
         hold_arm_next = 1'b1;
      end else if (hold_arm_reg && instr_done_i) begin
         hold_next     = 1'b0;
         hold_arm_next = 1'b0;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         hold_reg     <= 1'b0;
         hold_arm_reg <= 1'b0;
      end else begin
         hold_reg     <= hold_next;
         hold_arm_reg <= hold_arm_next;
      end
   end

   reg                  req_next;
   reg [`SRC_IDX_W-1:0] src_next;
   reg                  high_next;

   // The request drops at the edge that takes it or that sees a return
   always @* begin
      req_next  = cand_ok & ~req_taken & ~reti_i;
      src_next  = cand_idx;
      high_next = cand_high;
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         irq_req_o  <= 1'b0;
         irq_src_o  <= {`SRC_IDX_W{1'b0}};
         irq_high_o <= 1'b0;
      end else begin
         irq_req_o  <= req_next;
         irq_src_o  <= src_next;
         irq_high_o <= high_next;
      end
   end

   // Level bits are shown to other logic one cycle after a write lands
   always @(posedge clk_i) begin
      if (reset_i) begin
         src_high_o <= {SRC_N{1'b0}};
      end else begin
         src_high_o <= level_vec;
      end
   end

endmodule

// ===== irq_priority_regs.vh
`ifndef IRQ_PRIORITY_REGS_VH
`define IRQ_PRIORITY_REGS_VH

// Special function register addresses
`define IRQ_LEVEL_SELECT_ADDR    8'hB8
`define EXT_IRQ_ENABLE_ADDR      8'hE6
`define EXT_IRQ_LEVEL_ADDR       8'hF6

// Reset values
`define IRQ_LEVEL_SELECT_RESET   8'h80
`define EXT_IRQ_ENABLE_RESET     8'h00
`define EXT_IRQ_LEVEL_RESET      8'h00

// Writable and readable bit masks
`define IRQ_LEVEL_SELECT_WMASK   8'h7F
`define EXT_IRQ_WMASK            8'h1F
`define EXT_IRQ_READ_MASK        8'h1F

// Bit positions in the primary level register
`define LVL_EXT_EDGE1_BIT        6
`define LVL_TIMER3_BIT           5
`define LVL_SERIALIZER_BIT       4
`define LVL_CLOCK_TICK_BIT       3
`define LVL_RESERVED_BIT         2
`define LVL_TIMER2_BIT           1
`define LVL_EXT_EDGE0_BIT        0
`define LVL_FIXED_ONE_BIT        7
`define LVL_FIXED_ONE_SEL        3'h7

// Bit positions in the extended registers
`define EXT_SPARE1_BIT           4
`define EXT_SPARE0_BIT           3
`define EXT_FREQ_COUNTER_BIT     2

// Source indices, in natural priority order (0 first)
`define SRC_EXT_EDGE0            0
`define SRC_TIMER2               1
`define SRC_CLOCK_TICK           2
`define SRC_SERIALIZER           3
`define SRC_TIMER3               4
`define SRC_EXT_EDGE1            5
`define SRC_FREQ_COUNTER         6
`define SRC_SPARE0               7
`define SRC_SPARE1               8
`define SRC_COUNT                9
`define SRC_IDX_W                4

// Service tracking codes
`define LEVEL_NONE               2'h0
`define LEVEL_LOW                2'h1
`define LEVEL_HIGH               2'h2

`endif

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
   reg         clk_i = 0, reset_i = 1, wr = 0, bwr = 0, bval = 0, glob = 0, serve = 0;
   reg  [7:0]  adr = 8'h00, wd = 8'h00;
   reg  [2:0]  sel = 3'h0;
   reg  [5:0]  pen = 6'h00;
   reg  [8:0]  pend = 9'h000;
   wire [7:0]  rdata;
   wire        bit_q, ack, reti, done, req, high;
   wire [3:0]  src;
   wire [8:0]  lvl;
   integer     fail_count = 0, n_tests = 0, i, j;
   irq_priority_ext_enable u_dut (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(adr),
      .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(sel),
      .sfr_bit_val_i(bval), .sfr_rdata_o(rdata), .sfr_bit_rdata_o(bit_q),
      .global_irq_enable_i(glob), .primary_enable_i(pen), .irq_pending_i(pend),
      .irq_ack_i(ack), .reti_i(reti), .instr_done_i(done), .irq_req_o(req),
      .irq_src_o(src), .irq_high_o(high), .src_high_o(lvl));
   core_model u_core (.clk_i(clk_i), .reset_i(reset_i), .serve_i(serve), .irq_req_i(req),
      .ack_o(ack), .reti_o(reti), .done_o(done));
   always #4 clk_i = ~clk_i;
   task complete_run;
      if (fail_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input [8:0] got, input [8:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task wrb(input [7:0] a, input [7:0] d);
      adr = a;
      wd = d;
      wr = 1;
      tick(1);
      wr = 0;
      tick(1);
   endtask
   task bw(input [2:0] s, input v);
      adr = 8'hB8;
      sel = s;
      bval = v;
      bwr = 1;
      tick(1);
      bwr = 0;
      tick(1);
   endtask
   task rd(input [7:0] a, input [7:0] e);
      adr = a;
      tick(1);
      chk(rdata, e);
   endtask
   task hold(input k);
      j = 0;
      while ((k ? done : ack) !== 1'b1 && j < 60) begin
         tick(1);
         j = j + 1;
      end
      chk(j < 60, 1);
   endtask
   // Register bit of each source, in source index order
   function [7:0] bitof(input integer k);
      bitof = 8'h01 << (k < 2 ? k : k < 6 ? k + 1 : k - 4);
   endfunction
   initial begin
      #20000;
      fail_count = fail_count + 1;
      complete_run;
   end
   initial begin
      tick(8);
      reset_i = 0;
      rd(8'hB8, 8'h80);
      rd(8'hE6, 8'h00);
      rd(8'hF6, 8'h00);
      wrb(8'hB8, 8'h7B);
      rd(8'hB8, 8'hFB);
      wrb(8'hE6, 8'hFC);
      rd(8'hE6, 8'h1C);
      wrb(8'hF6, 8'hE0);
      rd(8'hF6, 8'h00);
      for (i = 0; i < 9; i = i + 1) begin
         wrb(8'hB8, i < 6 ? bitof(i) : 8'h00);
         wrb(8'hF6, i < 6 ? 8'h00 : bitof(i));
         chk(lvl, 9'h001 << i);
      end
      bw(3'h7, 1'b0);
      rd(8'hB8, 8'h80);
      bw(3'h6, 1'b1);
      rd(8'hB8, 8'hC0);
      bw(3'h6, 1'b0);
      rd(8'hB8, 8'h80);
      bw(3'h6, 1'b1);
      adr = 8'hB8;
      sel = 3'h3;
      tick(1);
      chk(bit_q, 0);
      adr = 8'hB8;
      sel = 3'h6;
      tick(1);
      chk(bit_q, 1);
      glob = 1;
      pen = 6'h3F;
      for (i = 6; i < 9; i = i + 1) begin
         pend = 9'h001 << i;
         wrb(8'hE6, 8'h1C ^ bitof(i));
         chk(req, 0);
         wrb(8'hE6, 8'h1C);
         chk({req, src}, {1'b1, i[3:0]});
      end
      pend = 9'h021;
      tick(2);
      chk({req, high, src}, {2'b11, 4'h5});
      glob = 0;
      tick(2);
      chk(req, 0);
      glob = 1;
      pen = 6'h1F;
      tick(2);
      chk({req, high, src}, {2'b10, 4'h0});
      pen = 6'h3F;
      pend = 9'h020;
      serve = 1;
      hold(0);
      tick(5);
      chk(req, 0);
      hold(1);
      serve = 0;
      chk(req, 0);
      tick(3);
      chk(req, 1);
      pend = 9'h001;
      tick(2);
      chk({req, high, src}, {2'b10, 4'h0});
      serve = 1;
      hold(0);
      serve = 0;
      pend = 9'h021;
      tick(3);
      chk({req, high, src}, {2'b11, 4'h5});
      complete_run;
   end
endmodule
